/* inc/fep_pkg.sv */
// Shared constants, code table and state types of the fast Ethernet coding path.
package fep_pkg;

   // Clock and timing.
   localparam int CLK_NS          = 10;
   localparam int HALF10_NS       = 50;
   localparam int HALF10_CYC      = (HALF10_NS + CLK_NS - 1) / CLK_NS;
   localparam int BIT10_CYC       = 2 * HALF10_CYC;
   localparam int SYM_BITS        = 5;
   localparam int NIB10_BITS      = 4;
   localparam int IDLE_WIN_BYTES  = 4000;
   localparam int CODE_BITS_BYTE  = 2 * SYM_BITS;
   localparam int IDLE_WIN_CODE   = IDLE_WIN_BYTES * CODE_BITS_BYTE;
   localparam int WIN_W           = 17;
   localparam int IDLE_RUN_BITS   = 2 * SYM_BITS;
   localparam int LOCK_BITS_DEF   = 30;

   // Scrambler taps and seed filler.
   localparam int          LFSR_W    = 11;
   localparam int          TAP_A     = 8;
   localparam int          TAP_B     = 10;
   localparam logic [5:0]  SEED_FILL = 6'h3f;

   // Five-bit control code-groups.
   localparam logic [4:0] CG_J = 5'h18;
   localparam logic [4:0] CG_K = 5'h11;
   localparam logic [4:0] CG_T = 5'h0d;
   localparam logic [4:0] CG_R = 5'h07;
   localparam logic [4:0] CG_I = 5'h1f;
   localparam logic [4:0] CG_H = 5'h04;

   // Receive nibbles with fixed meaning.
   localparam logic [3:0] NIB_SSD     = 4'h5;
   localparam logic [3:0] NIB_BAD_SSD = 4'he;

   // Line level codes for the three-level output.
   localparam logic [1:0] LVL_ZERO = 2'h0;
   localparam logic [1:0] LVL_PLUS = 2'h1;
   localparam logic [1:0] LVL_MIN  = 2'h3;

   typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_state_t;

   // Receive side decode result of one code-group.
   typedef struct packed {
      logic [3:0] nib;
      logic       is_data;
      logic       is_k;
      logic       is_t;
      logic       is_r;
      logic       is_i;
   } fep_dec_t;

   // MII transmit inputs from the MAC.
   typedef struct packed {
      logic [3:0] nibble;
      logic       valid;
      logic       error;
   } fep_mii_tx_t;

   // MII receive outputs to the MAC.
   typedef struct packed {
      logic [3:0] nibble;
      logic       valid;
      logic       error;
      logic       clock;
      logic       carrier;
   } fep_mii_rx_t;

   // Whole state of the coding path.
   typedef struct packed {
      fep_tx_state_t     txs;
      logic [3:0]        sub;
      logic [2:0]        bitc;
      logic              txclk;
      logic [4:0]        sym;
      logic [3:0]        nib10;
      logic              act10;
      logic [LFSR_W-1:0] txlfsr;
      logic              seeded;
      logic              nrzi;
      logic [1:0]        mph;
      logic [1:0]        mlt;
      logic              man;
      logic [1:0]        lvl1;
      logic [1:0]        lvl2;
      logic [1:0]        lvlp;
      logic              lf1;
      logic              lf2;
      logic              sp1;
      logic              sp2;
      logic [LFSR_W-1:0] rxlfsr;
      logic              locked;
      logic [5:0]        mcnt;
      logic [14:0]       rsh;
      logic [WIN_W-1:0]  win;
      logic [3:0]        ones;
      logic [2:0]        rph;
      logic              inframe;
      logic [4:0]        held;
      fep_mii_rx_t       rx;
   } fep_state_t;

   function automatic logic [4:0] fep_encode(input logic [3:0] n);
      logic [4:0] c;
      c = CG_I;
      unique case (n)
         4'h0: c = 5'h1e;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0a;
         4'h5: c = 5'h0b;
         4'h6: c = 5'h0e;
         4'h7: c = 5'h0f;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'ha: c = 5'h16;
         4'hb: c = 5'h17;
         4'hc: c = 5'h1a;
         4'hd: c = 5'h1b;
         4'he: c = 5'h1c;
         4'hf: c = 5'h1d;
      endcase
      return c;
   endfunction

endpackage

/* verilog/fep_dec5.sv */
// Five-bit to four-bit code-group decoder with control symbol flags.
`timescale 1ns/100ps
module fep_dec5
   import fep_pkg::*;
(
   // Code-group in, decode out.
   input  wire logic [4:0] code_i,
   output fep_dec_t        dec_o
);

   always_comb begin
      dec_o = '0;
      for (int n = 0; n < 16; n++) begin
         if (fep_encode(4'(n)) == code_i) begin
            dec_o.nib     = 4'(n);
            dec_o.is_data = 1'b1;
         end
      end
      dec_o.is_k = (code_i == CG_K);
      dec_o.is_t = (code_i == CG_T);
      dec_o.is_r = (code_i == CG_R);
      dec_o.is_i = (code_i == CG_I);
   end

endmodule

/* verilog/fep_pcs.sv */
// Fast Ethernet coding path: MII transmit to MLT-3 or Manchester, line to MII receive.
`timescale 1ns/100ps
// Contract
// - Capture nibble each transmit clock rise
// - Data nibbles map to sixteen code-groups
// - Send idle between frames, H for errors
// - Scrambler seeded from address, serialises groups
// - Scrambled stream is NRZI coded
// - One bits step MLT-3 level, zeros hold
// - Descrambler learns key on idles, then holds
// - Idles must appear within 4000-byte window
// - Missing idles abort reception, reacquire key
// - J/K sets alignment until next frame
// - Decode groups; J/K gives two 0101 nibbles
// - Valid rises with first delimiter nibble
// - T/R or two idles end frame
// - Link failure drops receive valid
// - Unexpected group in frame raises error
// - Bad start delimiter gives error and 1110
// - Receive clock recovered, else from reference (fast mode only; in 10 Mbit mode the group phase keeps counting)
// - 10 Mbit nibbles serialised, Manchester coded
// - Device drives the transmit clock
module fep_pcs
   import fep_pkg::*;
#(
   parameter int IDLE_WIN_BITS = IDLE_WIN_CODE,
   parameter int LOCK_BITS     = LOCK_BITS_DEF
)
(
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Configuration.
   input  wire logic [4:0] phy_addr_i,
   input  wire logic       speed_10_i,
   // Line status from the analog side.
   input  wire logic       link_fail_i,
   input  wire logic       rx_signal_present_i,
   input  wire logic [1:0] rx_mlt3_i,
   // MII transmit.
   input  wire logic [3:0] tx_nibble_bus_i,
   input  wire logic       tx_valid_strobe_i,
   input  wire logic       tx_error_strobe_i,
   output logic            tx_mii_clock_o,
   // MII receive.
   output logic [3:0]      rx_nibble_bus_o,
   output logic            rx_valid_strobe_o,
   output logic            rx_error_strobe_o,
   output logic            rx_mii_clock_o,
   output logic            carrier_sense_o,
   // Line outputs.
   output logic            nrzi_o,
   output logic [1:0]      mlt3_o,
   output logic            manchester_o
);

   fep_state_t  s_r;
   fep_state_t  s_nxt;
   fep_mii_tx_t mtx;
   fep_dec_t    dec_held;
   fep_dec_t    dec_cur;
   logic [14:0] rsh_n;

   assign mtx = '{nibble: tx_nibble_bus_i, valid: tx_valid_strobe_i, error: tx_error_strobe_i};

   fep_dec5 u_dec_held (
      .code_i (s_r.held),
      .dec_o  (dec_held)
   );

   fep_dec5 u_dec_cur (
      .code_i (rsh_n[4:0]),
      .dec_o  (dec_cur)
   );

   always_comb begin
      logic [3:0] sub_lim;
      logic [2:0] bit_lim;
      logic       bnd;
      logic       sbit;
      logic       fb;
      logic       scr;
      logic       cbit;
      logic       rfb;
      logic       pbit;
      logic       idle_seen;
      logic       grp;
      logic       fin;
      sub_lim   = speed_10_i ? 4'(BIT10_CYC - 1) : 4'h0;
      bit_lim   = speed_10_i ? 3'(NIB10_BITS - 1) : 3'(SYM_BITS - 1);
      bnd       = (s_r.sub == sub_lim) && (s_r.bitc == bit_lim);
      s_nxt     = s_r;
      sbit      = 1'b0;
      fb        = 1'b0;
      scr       = 1'b0;
      cbit      = 1'b0;
      rfb       = 1'b0;
      pbit      = 1'b0;
      idle_seen = 1'b0;
      grp       = 1'b0;
      fin       = 1'b0;
      rsh_n     = s_r.rsh;

      // Nibble timing; the transmit clock rises on the boundary edge.
      if (s_r.sub == sub_lim) begin
         s_nxt.sub  = 4'h0;
         s_nxt.bitc = (s_r.bitc == bit_lim) ? 3'h0 : s_r.bitc + 3'h1;
      end else begin
         s_nxt.sub = s_r.sub + 4'h1;
      end
      s_nxt.txclk = (s_nxt.bitc < 3'h2);

      // Fast mode: one code bit per clock, five per nibble.
      if (!speed_10_i) begin
         sbit       = s_r.sym[4];
         s_nxt.sym  = {s_r.sym[3:0], 1'b0};
         fb         = s_r.txlfsr[TAP_A] ^ s_r.txlfsr[TAP_B];
         s_nxt.txlfsr = {s_r.txlfsr[LFSR_W-2:0], fb};
         scr        = sbit ^ fb;
         s_nxt.nrzi = s_r.nrzi ^ scr;
         if (s_nxt.nrzi != s_r.nrzi) begin
            s_nxt.mph = s_r.mph + 2'h1;
         end
         s_nxt.mlt = s_nxt.mph[0] ? (s_nxt.mph[1] ? LVL_MIN : LVL_PLUS) : LVL_ZERO;
         if (bnd) begin
            // The nibble is taken on the rising edge of the transmit clock.
            unique case (s_r.txs)
               TX_IDLE: begin
                  if (mtx.valid) begin
                     s_nxt.sym = CG_J;
                     s_nxt.txs = TX_K;
                  end else begin
                     s_nxt.sym = CG_I;
                  end
               end
               TX_K: begin
                  s_nxt.sym = CG_K;
                  s_nxt.txs = TX_DATA;
               end
               TX_DATA: begin
                  if (mtx.valid) begin
                     s_nxt.sym = mtx.error ? CG_H : fep_encode(mtx.nibble);
                  end else begin
                     s_nxt.sym = CG_T;
                     s_nxt.txs = TX_R;
                  end
               end
               TX_R: begin
                  s_nxt.sym = CG_R;
                  s_nxt.txs = TX_IDLE;
               end
            endcase
         end
         s_nxt.act10 = 1'b0;
         s_nxt.man   = 1'b0;
      end else begin
         // Slow mode: four bits per nibble, least significant first.
         s_nxt.txs = TX_IDLE;
         s_nxt.man = s_r.act10 & ((s_r.sub < 4'(HALF10_CYC)) ? ~s_r.nib10[0] : s_r.nib10[0]);
         if (s_r.sub == sub_lim) begin
            s_nxt.nib10 = {1'b0, s_r.nib10[3:1]};
         end
         if (bnd) begin
            s_nxt.nib10 = mtx.nibble;
            s_nxt.act10 = mtx.valid;
         end
      end

      // The seed is loaded on the first edge after reset, never by the reset itself.
      if (!s_r.seeded) begin
         s_nxt.seeded = 1'b1;
         s_nxt.txlfsr = {phy_addr_i, SEED_FILL};
      end

      // Line and status inputs pass two flip-flops.
      s_nxt.lvl1 = rx_mlt3_i;
      s_nxt.lvl2 = s_r.lvl1;
      s_nxt.lf1  = link_fail_i;
      s_nxt.lf2  = s_r.lf1;
      s_nxt.sp1  = rx_signal_present_i;
      s_nxt.sp2  = s_r.sp1;
      s_nxt.lvlp = s_r.lvl2;

      // Any level change is a code bit of one.
      cbit = (s_r.lvl2 != s_r.lvlp);
      rfb  = s_r.rxlfsr[TAP_A] ^ s_r.rxlfsr[TAP_B];
      if (!s_r.locked) begin
         // During idle the plain bits are all ones, so the inverted line bit is the key.
         s_nxt.rxlfsr = {s_r.rxlfsr[LFSR_W-2:0], ~cbit};
         if (rfb == ~cbit) begin
            if (s_r.mcnt == 6'(LOCK_BITS - 1)) begin
               s_nxt.locked = 1'b1;
               s_nxt.mcnt   = 6'h0;
               s_nxt.win    = '0;
            end else begin
               s_nxt.mcnt = s_r.mcnt + 6'h1;
            end
         end else begin
            s_nxt.mcnt = 6'h0;
         end
      end else begin
         s_nxt.rxlfsr = {s_r.rxlfsr[LFSR_W-2:0], rfb};
         pbit         = cbit ^ rfb;
      end
      rsh_n     = {s_r.rsh[13:0], pbit};
      s_nxt.rsh = rsh_n;
      s_nxt.ones = pbit ? ((s_r.ones == 4'hf) ? 4'hf : s_r.ones + 4'h1) : 4'h0;
      idle_seen  = (s_nxt.ones >= 4'(IDLE_RUN_BITS));

      // Receive clock: group phase, or transmit timing in fast mode when no signal is present.
      s_nxt.rph = (s_r.rph == 3'(SYM_BITS - 1)) ? 3'h0 : s_r.rph + 3'h1;
      grp       = (s_r.rph == 3'(SYM_BITS - 1));
      if (!s_r.sp2) begin
         s_nxt.rph = speed_10_i ? s_nxt.rph : s_nxt.bitc;
      end

      if (!s_r.inframe) begin
         if (grp) begin
            s_nxt.rx.valid = 1'b0;
            s_nxt.rx.error = 1'b0;
         end
         if (s_r.locked && (rsh_n[9:0] == {CG_J, CG_K})) begin
            s_nxt.inframe   = 1'b1;
            s_nxt.rph       = 3'h0;
            s_nxt.held      = CG_K;
            s_nxt.rx.nibble = NIB_SSD;
            s_nxt.rx.valid  = 1'b1;
            s_nxt.rx.error  = 1'b0;
         end else if (s_r.locked && (rsh_n[14:10] == CG_I) && (rsh_n[9:5] == CG_J)) begin
            s_nxt.rph       = 3'h0;
            s_nxt.rx.nibble = NIB_BAD_SSD;
            s_nxt.rx.error  = 1'b1;
            s_nxt.rx.valid  = 1'b0;
         end
      end else if (grp) begin
         s_nxt.held = rsh_n[4:0];
         if (dec_held.is_t) begin
            fin = dec_cur.is_r;
            s_nxt.rx.error = ~dec_cur.is_r;
         end else if (dec_held.is_i) begin
            fin = dec_cur.is_i;
            s_nxt.rx.error = ~dec_cur.is_i;
         end else if (dec_held.is_k) begin
            s_nxt.rx.nibble = NIB_SSD;
            s_nxt.rx.error  = 1'b0;
         end else if (dec_held.is_data) begin
            s_nxt.rx.nibble = dec_held.nib;
            s_nxt.rx.error  = 1'b0;
         end else begin
            s_nxt.rx.error = 1'b1;
         end
         s_nxt.rx.valid = 1'b1;
      end

      // Idle watchdog on the locked key.
      if (s_r.locked) begin
         s_nxt.win = idle_seen ? '0 : s_r.win + WIN_W'(1);
         if (s_r.win == WIN_W'(IDLE_WIN_BITS - 1)) begin
            s_nxt.locked = 1'b0;
            s_nxt.win    = '0;
            fin          = 1'b1;
         end
      end
      if (s_r.lf2) begin
         fin = 1'b1;
      end
      if (fin) begin
         s_nxt.inframe  = 1'b0;
         s_nxt.rx.valid = 1'b0;
         s_nxt.rx.error = 1'b0;
      end
      s_nxt.rx.carrier = s_nxt.inframe;
      // Outputs change two clocks before the receive clock rises.
      s_nxt.rx.clock = (s_nxt.rph == 3'h2) || (s_nxt.rph == 3'h3);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r        <= '0;
         // Starting the bit count at its wrap point keeps the first clock pulse full width.
         s_r.bitc   <= '1;
         s_r.txs    <= TX_IDLE;
         s_r.sym    <= CG_I;
         s_r.txlfsr <= {5'h00, SEED_FILL};
         s_r.rxlfsr <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tx_mii_clock_o    = s_r.txclk;
   assign rx_nibble_bus_o   = s_r.rx.nibble;
   assign rx_valid_strobe_o = s_r.rx.valid;
   assign rx_error_strobe_o = s_r.rx.error;
   assign rx_mii_clock_o    = s_r.rx.clock;
   assign carrier_sense_o   = s_r.rx.carrier;
   assign nrzi_o            = s_r.nrzi;
   assign mlt3_o            = s_r.mlt;
   assign manchester_o      = s_r.man;

endmodule

/* bench/fep_pcs_checker.sv */
// Port assertions of the fast Ethernet coding path.
`timescale 1ns/100ps
module fep_pcs_checker
   import fep_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       speed_10_i,
   input wire logic       link_fail_i,
   input wire logic       tx_mii_clock_o,
   input wire logic [3:0] rx_nibble_bus_o,
   input wire logic       rx_valid_strobe_o,
   input wire logic       rx_error_strobe_o,
   input wire logic       rx_mii_clock_o,
   input wire logic       carrier_sense_o,
   input wire logic [1:0] mlt3_o,
   input wire logic       nrzi_o
);
   logic [1:0] lastnz_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Reset to minus so that the first step away from zero must go to plus.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) lastnz_r <= LVL_MIN;
      else if (mlt3_o != LVL_ZERO) lastnz_r <= mlt3_o;
   end

   sequence s_txclk_high; tx_mii_clock_o [*2]; endsequence
   sequence s_txclk_low;  !tx_mii_clock_o [*3]; endsequence
   sequence s_ssd_start;  $rose(rx_valid_strobe_o) && rx_nibble_bus_o == NIB_SSD; endsequence

   a_txclk_shape: assert property (($rose(tx_mii_clock_o) && !speed_10_i) |->
      s_txclk_high ##1 s_txclk_low ##1 tx_mii_clock_o) else $error("tx clock shape");
   a_mlt3_order: assert property ($changed(mlt3_o) |-> ((mlt3_o == LVL_ZERO) ?
      $past(mlt3_o) != LVL_ZERO : mlt3_o != lastnz_r)) else $error("mlt3 order");
   a_ssd_pair: assert property ($rose(rx_valid_strobe_o) |->
      s_ssd_start ##0 carrier_sense_o ##5 rx_nibble_bus_o == NIB_SSD) else $error("ssd");
   a_link_drop: assert property (link_fail_i [*4] |->
      ##1 !rx_valid_strobe_o && !carrier_sense_o) else $error("link fail");
   a_err_frame: assert property ((rx_error_strobe_o && $past(rx_valid_strobe_o)
      && carrier_sense_o) |-> rx_valid_strobe_o) else $error("error in frame");
   a_bad_ssd: assert property ((rx_error_strobe_o && !rx_valid_strobe_o) |->
      rx_nibble_bus_o == NIB_BAD_SSD) else $error("bad ssd nibble");
   a_rx_hold: assert property (($changed(rx_nibble_bus_o) && rx_valid_strobe_o) |=>
      (!rx_valid_strobe_o || $stable(rx_nibble_bus_o)) [*4]) else $error("rx hold");
   a_rxclk_after: assert property (($changed(rx_nibble_bus_o) && rx_valid_strobe_o) |->
      ##2 $rose(rx_mii_clock_o)) else $error("rx clock phase");
   a_valid_carrier: assert property (rx_valid_strobe_o |-> carrier_sense_o)
      else $error("valid without carrier");
   a_nrzi_mlt3: assert property ($changed(nrzi_o) == $changed(mlt3_o))
      else $error("nrzi and mlt3 disagree");
endmodule

bind fep_pcs fep_pcs_checker chk_u (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .speed_10_i(speed_10_i), .link_fail_i(link_fail_i),
   .tx_mii_clock_o(tx_mii_clock_o), .rx_nibble_bus_o(rx_nibble_bus_o),
   .rx_valid_strobe_o(rx_valid_strobe_o), .rx_error_strobe_o(rx_error_strobe_o),
   .rx_mii_clock_o(rx_mii_clock_o), .carrier_sense_o(carrier_sense_o), .mlt3_o(mlt3_o),
   .nrzi_o(nrzi_o)
);

/* bench/fep_mac_model.sv */
// MAC side model: sends transmit frames and collects received nibbles.
`timescale 1ns/100ps
module fep_mac_model
   import fep_pkg::*;
(
   // MII clocks from the device.
   input  wire logic        tx_clk_i,
   input  wire logic        rx_clk_i,
   // MII receive in, transmit out.
   input  wire fep_mii_rx_t rx_i,
   output fep_mii_tx_t      tx_o
);
   logic [3:0] rx_q[$];
   int         rx_err = 0;

   initial tx_o = '0;

   always @(posedge rx_clk_i) begin
      if (rx_i.valid === 1'b1) begin
         rx_q.push_back(rx_i.nibble);
         if (rx_i.error === 1'b1) rx_err++;
      end
   end

   // After the frame the bus shows the inverted last nibble, never a stale copy.
   task automatic send(input logic [3:0] d[$], input int err_at);
      foreach (d[i]) begin
         @(posedge tx_clk_i);
         #1 tx_o = '{nibble: d[i], valid: 1'b1, error: (i == err_at)};
      end
      @(posedge tx_clk_i);
      #1 tx_o = '{nibble: ~tx_o.nibble, valid: 1'b0, error: 1'b0};
   endtask
endmodule

/* bench/fast_ethernet_pcs_datapath_test.sv */
// Loopback bench of the fast Ethernet coding path.
`timescale 1ns/100ps
module fast_ethernet_pcs_datapath_test;
   import fep_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [4:0]  phy_addr_i = 5'h00;
   logic        speed_10_i = 1'b0;
   logic        link_fail_i = 1'b0;
   logic        sig_i = 1'b1;
   logic        txclk;
   logic        nrzi;
   logic        man;
   logic [1:0]  mlt3;
   logic [3:0]  n10;
   fep_mii_tx_t tx;
   wire fep_mii_rx_t rx;
   logic [31:0] seed = 32'h21a0;
   logic [3:0]  d[$];
   int          err_total = 0;
   int          num_checks = 0;

   always #5 clk_i = ~clk_i;

   // A stalled clock or handshake must still reach the verdict.
   initial begin
      repeat (50000) @(posedge clk_i);
      err_total++;
      end_sim();
   end

   // The line output is looped straight back into the receiver.
   fep_pcs #(.IDLE_WIN_BITS(200), .LOCK_BITS(15)) dut_u (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .phy_addr_i(phy_addr_i), .speed_10_i(speed_10_i),
      .link_fail_i(link_fail_i), .rx_signal_present_i(sig_i), .rx_mlt3_i(mlt3),
      .tx_nibble_bus_i(tx.nibble), .tx_valid_strobe_i(tx.valid),
      .tx_error_strobe_i(tx.error), .tx_mii_clock_o(txclk), .rx_nibble_bus_o(rx.nibble),
      .rx_valid_strobe_o(rx.valid), .rx_error_strobe_o(rx.error),
      .rx_mii_clock_o(rx.clock), .carrier_sense_o(rx.carrier), .nrzi_o(nrzi),
      .mlt3_o(mlt3), .manchester_o(man));
   fep_mac_model mac_u (.tx_clk_i(txclk), .rx_clk_i(rx.clock), .rx_i(rx), .tx_o(tx));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic same(input logic [3:0] a[$], input logic [3:0] b[$]);
      if (a.size() != b.size()) return 1'b0;
      foreach (a[i]) if (a[i] !== b[i]) return 1'b0;
      return 1'b1;
   endfunction

   // First half of a bit cell carries the inverted bit, LSB goes first.
   function automatic logic exp_man(input logic [3:0] n, input int k);
      return ((k - 1) % 10 < 5) ? ~n[(k - 1) / 10] : n[(k - 1) / 10];
   endfunction

   task end_sim;
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task wait_idle;
      int n;
      int run;
      n = 0;
      run = 0;
      while (run < 30 && n < 2000) begin
         @(posedge clk_i);
         n++;
         run = (rx.carrier === 1'b0) ? run + 1 : 0;
      end
      if (n >= 2000) begin
         err_total++;
         end_sim();
      end
   endtask

   // Kind 1 sends all-zero data, kind 2 all-ones data, otherwise random nibbles.
   task frame(input int len, input int err_at, input logic lf, input int kind);
      d = {4'h5, 4'h5};
      for (int i = 2; i < len; i++) begin
         seed = lfsr(seed);
         d.push_back(kind == 1 ? 4'h0 : kind == 2 ? 4'hf : seed[3:0]);
      end
      repeat (100) @(posedge clk_i);
      mac_u.rx_q.delete();
      mac_u.rx_err = 0;
      fork
         mac_u.send(d, err_at);
         if (lf) begin
            repeat (60) @(posedge clk_i);
            #1 link_fail_i = 1'b1;
            repeat (10) @(posedge clk_i);
            #1 link_fail_i = 1'b0;
         end
      join
      wait_idle();
   endtask

   initial begin
      seed = lfsr(seed);
      phy_addr_i = seed[4:0];
      repeat (3) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      for (int f = 0; f < 6; f++) begin
         seed = lfsr(seed);
         frame(8 + int'(seed[4:0] % 23), -1, 1'b0, f % 3);
         chk(same(mac_u.rx_q, d) && mac_u.rx_err == 0, "frame data");
      end
      frame(12, 5, 1'b0, 0);
      chk(mac_u.rx_q.size() == 12 && mac_u.rx_err != 0, "error frame");
      frame(30, -1, 1'b1, 0);
      chk(mac_u.rx_q.size() > 2 && mac_u.rx_q.size() < 30, "link fail frame");
      frame(70, -1, 1'b0, 0);
      chk(mac_u.rx_q.size() > 20 && mac_u.rx_q.size() < 70, "overlong frame");
      frame(10, -1, 1'b0, 0);
      chk(same(mac_u.rx_q, d), "frame after relock");
      // Speed is changed under reset so no half-finished period is judged.
      #1 rst_b_i = 1'b0;
      speed_10_i = 1'b1;
      seed = lfsr(seed);
      n10 = seed[3:0];
      d = {n10};
      @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      fork
         mac_u.send(d, -1);
         begin
            @(posedge txclk);
            @(posedge txclk);
            for (int k = 1; k <= 40; k++) begin
               @(posedge clk_i);
               #1;
               if (k % 10 == 3 || k % 10 == 8) chk(man === exp_man(n10, k), "manchester");
            end
         end
      join
      end_sim();
   end
endmodule
